// ### design/jlo_regs.svh
// register offsets, field positions, reset values and defaults of the link override bank
`ifndef JLO_REGS_SVH
`define JLO_REGS_SVH

`define JLO_ADDR_LANE_CTRL      8'h73
`define JLO_ADDR_FCHK_12        8'h74
`define JLO_ADDR_FCHK_34        8'h75
`define JLO_ADDR_IDENT_12       8'h76
`define JLO_ADDR_IDENT_34       8'h77
`define JLO_ADDR_MF_FORCE       8'h78
`define JLO_ADDR_VER_SUB        8'h55

`define JLO_RST_VALUE           16'h0000

`define JLO_CTRL_IDENT_MSB      15
`define JLO_CTRL_FCHK_MSB       11
`define JLO_CTRL_VER_UNLOCK     4
`define JLO_CTRL_WMASK          16'hff10

`define JLO_HI_FIELD_LSB        8
`define JLO_IDENT_WMASK         16'h1f1f
`define JLO_MF_FORCE_BIT        15
`define JLO_MF_START_LSB        10
`define JLO_MF_WMASK            16'hfc00
`define JLO_VER_SUB_WMASK       16'he0e0
`define JLO_SUBCLASS_LSB        13
`define JLO_VERSION_LSB         5

`define JLO_SUBCLASS_DEFAULT    3'h1
`define JLO_VERSION_DEFAULT     3'h1
`define JLO_MF_START_DEFAULT    5'h00

`endif

// ### design/jlo_pkg.sv
// types shared by the link override register bank
package jlo_pkg;

    typedef struct packed {
        logic [15:0] lane_override_control;
        logic [15:0] forced_checksum_lanes_1_2;
        logic [15:0] forced_checksum_lanes_3_4;
        logic [15:0] forced_lane_ident_1_2;
        logic [15:0] forced_lane_ident_3_4;
        logic [15:0] multiframe_counter_force;
        logic [15:0] version_subclass;
        logic [15:0] rdata;
    } jlo_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } jlo_bus_req_t;

    typedef struct packed {
        logic [19:0] lane_ident;
        logic [31:0] lane_fchk;
        logic [2:0]  link_subclass_select;
        logic [2:0]  link_standard_version;
        logic        multiframe_counter_force_en;
        logic [4:0]  multiframe_counter_start;
    } jlo_link_cfg_t;

endpackage

// ### design/jlo_override_bank.sv
// link parameter override register bank with per-lane identifier and checksum selection
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "jlo_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - control bits 15..12 enable lane 1..4 ident override, else ident 1..4 sent.
// - lane 1 ident from 0x76 bits 12-8, lane 2 from bits 4-0.
// - lane 3 ident from 0x77 bits 12-8, lane 4 from bits 4-0.
// - control bits 11..8 pick forced or computed checksum for lanes 1..4.
// - lane 1 forced checksum 0x74 bits 15-8, lane 2 bits 7-0.
// - lane 3 forced checksum 0x75 bits 15-8, lane 4 bits 7-0.
// - control bit 4 clear forces version B subclass 1; set lets fields act.
// - 0x78 bit 15 set loads counter start from bits 14-10, else default.
// - subclass codes 000/001/010 select 0/1/2; version 000=A, 001=B.
module jlo_override_bank #(
    parameter int LANES = 4
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [15:0]           reg_rdata,
    // checksums the transmitter computes itself, lane 1 in the low byte
    input  wire logic [LANES*8-1:0]    computed_fchk,
    // effective link parameters
    output jlo_pkg::jlo_link_cfg_t     link_cfg
);

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        if (LANES != 4)
            $error("jlo_override_bank serves exactly four lanes");
    end

    jlo_pkg::jlo_state_t   st_r;
    jlo_pkg::jlo_state_t   st_nxt;
    jlo_pkg::jlo_bus_req_t req;
    jlo_pkg::jlo_link_cfg_t cfg_nxt;
    jlo_pkg::jlo_link_cfg_t cfg_r;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    // masked write: reserved bits are dropped so they always read zero
    function automatic logic [15:0] wr_field(input logic [15:0] old_v,
                                             input logic [15:0] mask,
                                             input logic        hit,
                                             input logic [15:0] wd);
        wr_field = hit ? (wd & mask) : old_v;
    endfunction

    // picks the 8/5-bit field for a lane from a pair register: odd lane high
    function automatic logic [7:0] pair_field(input logic [15:0] r, input int lane);
        pair_field = (lane % 2 == 0) ? r[15:8] : r[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.lane_override_control = wr_field(st_r.lane_override_control,
            `JLO_CTRL_WMASK, req.wr && req.addr == `JLO_ADDR_LANE_CTRL, req.wdata);
        st_nxt.forced_checksum_lanes_1_2 = wr_field(st_r.forced_checksum_lanes_1_2,
            16'hffff, req.wr && req.addr == `JLO_ADDR_FCHK_12, req.wdata);
        st_nxt.forced_checksum_lanes_3_4 = wr_field(st_r.forced_checksum_lanes_3_4,
            16'hffff, req.wr && req.addr == `JLO_ADDR_FCHK_34, req.wdata);
        st_nxt.forced_lane_ident_1_2 = wr_field(st_r.forced_lane_ident_1_2,
            `JLO_IDENT_WMASK, req.wr && req.addr == `JLO_ADDR_IDENT_12, req.wdata);
        st_nxt.forced_lane_ident_3_4 = wr_field(st_r.forced_lane_ident_3_4,
            `JLO_IDENT_WMASK, req.wr && req.addr == `JLO_ADDR_IDENT_34, req.wdata);
        st_nxt.multiframe_counter_force = wr_field(st_r.multiframe_counter_force,
            `JLO_MF_WMASK, req.wr && req.addr == `JLO_ADDR_MF_FORCE, req.wdata);
        st_nxt.version_subclass = wr_field(st_r.version_subclass,
            `JLO_VER_SUB_WMASK, req.wr && req.addr == `JLO_ADDR_VER_SUB, req.wdata);
        // read data valid only in the cycle after the strobe; unmapped reads zero
        st_nxt.rdata = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                `JLO_ADDR_LANE_CTRL: st_nxt.rdata = st_r.lane_override_control;
                `JLO_ADDR_FCHK_12:   st_nxt.rdata = st_r.forced_checksum_lanes_1_2;
                `JLO_ADDR_FCHK_34:   st_nxt.rdata = st_r.forced_checksum_lanes_3_4;
                `JLO_ADDR_IDENT_12:  st_nxt.rdata = st_r.forced_lane_ident_1_2;
                `JLO_ADDR_IDENT_34:  st_nxt.rdata = st_r.forced_lane_ident_3_4;
                `JLO_ADDR_MF_FORCE:  st_nxt.rdata = st_r.multiframe_counter_force;
                `JLO_ADDR_VER_SUB:   st_nxt.rdata = st_r.version_subclass;
                default:             st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // effective per-lane values are built from the registered state and the computed_fchk input, then registered so that
    // the link side sees a glitch-free, registered configuration
    always_comb
    begin
        logic [15:0] ctl;
        logic [15:0] idr;
        logic [15:0] fkr;
        logic [7:0]  idf;
        ctl = st_r.lane_override_control;
        idr = 16'h0000;
        fkr = 16'h0000;
        idf = 8'h00;
        cfg_nxt = '0;
        for (int l = 0; l < 4; l++)
        begin
            idr = (l < 2) ? st_r.forced_lane_ident_1_2 : st_r.forced_lane_ident_3_4;
            fkr = (l < 2) ? st_r.forced_checksum_lanes_1_2 : st_r.forced_checksum_lanes_3_4;
            idf = pair_field(idr, l);
            if (ctl[`JLO_CTRL_IDENT_MSB - l])
                cfg_nxt.lane_ident[l*5 +: 5] = idf[4:0];
            else
                cfg_nxt.lane_ident[l*5 +: 5] = 5'(l + 1);
            if (ctl[`JLO_CTRL_FCHK_MSB - l])
                cfg_nxt.lane_fchk[l*8 +: 8] = pair_field(fkr, l);
            else
                cfg_nxt.lane_fchk[l*8 +: 8] = computed_fchk[l*8 +: 8];
        end
        if (ctl[`JLO_CTRL_VER_UNLOCK])
        begin
            cfg_nxt.link_subclass_select =
                st_r.version_subclass[`JLO_SUBCLASS_LSB +: 3];
            cfg_nxt.link_standard_version =
                st_r.version_subclass[`JLO_VERSION_LSB +: 3];
        end
        else
        begin
            cfg_nxt.link_subclass_select  = `JLO_SUBCLASS_DEFAULT;
            cfg_nxt.link_standard_version = `JLO_VERSION_DEFAULT;
        end
        cfg_nxt.multiframe_counter_force_en =
            st_r.multiframe_counter_force[`JLO_MF_FORCE_BIT];
        cfg_nxt.multiframe_counter_start = cfg_nxt.multiframe_counter_force_en ?
            st_r.multiframe_counter_force[`JLO_MF_START_LSB +: 5] :
            `JLO_MF_START_DEFAULT;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st_r  <= '0;
            cfg_r <= '0;
        end
        else
        begin
            st_r  <= st_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign link_cfg  = cfg_r;

endmodule // jlo_override_bank

// ### tb/jlo_properties.sv
// concurrent checks on the ports of the link override bank
`timescale 1ns/1ps
`include "jlo_regs.svh"
module jlo_props #(
    parameter int LANES = 4
) (
    // clock, reset, register port
    input wire logic                   mclk,
    input wire logic                   rst_b,
    input wire logic [7:0]             reg_addr,
    input wire logic [15:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [15:0]            reg_rdata,
    // link side
    input wire logic [LANES*8-1:0]     computed_fchk,
    input wire jlo_pkg::jlo_link_cfg_t link_cfg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire       wc  = reg_wr && reg_addr == `JLO_ADDR_LANE_CTRL;
    wire [4:0] hi5 = reg_wdata[12:8];
    wire [4:0] lo5 = reg_wdata[4:0];
    wire [7:0] hi8 = reg_wdata[15:8];
    wire [7:0] lo8 = reg_wdata[7:0];
    wire [5:0] sv6 = {reg_wdata[15:13], reg_wdata[7:5]};
    wire [5:0] mf6 = reg_wdata[15] ? reg_wdata[15:10] : 6'h00;
    ////////////////////////////////////////////////////////////////////////////
    // field register written, then the control register with bits m set
    sequence s_pre(a, m);
        reg_wr && reg_addr == a ##1 wc && (reg_wdata & m) == m;
    endsequence
    AST_ID_DEF: assert property (wc && reg_wdata[15:12] == 4'h0 |-> ##2
        link_cfg.lane_ident == {5'h04, 5'h03, 5'h02, 5'h01}) else $error("default ident");
    AST_ID12: assert property (s_pre(`JLO_ADDR_IDENT_12, 16'hc000) |-> ##2
        link_cfg.lane_ident[9:0] == {$past(lo5, 3), $past(hi5, 3)}) else $error("ident 1/2");
    AST_ID34: assert property (s_pre(`JLO_ADDR_IDENT_34, 16'h3000) |-> ##2
        link_cfg.lane_ident[19:10] == {$past(lo5, 3), $past(hi5, 3)}) else $error("ident 3/4");
    AST_FCHK_DEF: assert property (wc && reg_wdata[11:8] == 4'h0 |-> ##2
        link_cfg.lane_fchk == $past(computed_fchk)) else $error("computed checksum");
    AST_FCHK12: assert property (s_pre(`JLO_ADDR_FCHK_12, 16'h0c00) |-> ##2
        link_cfg.lane_fchk[15:0] == {$past(lo8, 3), $past(hi8, 3)}) else $error("fchk 1/2");
    AST_VER_LOCK: assert property (wc && !reg_wdata[4] |-> ##2
        link_cfg.link_subclass_select == 3'h1 && link_cfg.link_standard_version == 3'h1)
        else $error("locked version");
    AST_VER_OPEN: assert property (s_pre(`JLO_ADDR_VER_SUB, 16'h0010) |-> ##2
        {link_cfg.link_subclass_select, link_cfg.link_standard_version} == $past(sv6, 3))
        else $error("unlocked version");
    AST_MF: assert property (reg_wr && reg_addr == `JLO_ADDR_MF_FORCE |-> ##2
        {link_cfg.multiframe_counter_force_en, link_cfg.multiframe_counter_start}
        == $past(mf6, 2)) else $error("multiframe start");
endmodule // jlo_props

bind jlo_override_bank jlo_props #(.LANES(LANES)) jlo_props_inst (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .computed_fchk(computed_fchk), .link_cfg(link_cfg));

// ### tb/jlo_rx_model.sv
// receiving end of the link: takes up the parameters the transmitter advertises
`timescale 1ns/1ps
module jlo_rx_model (
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst_b,
    // advertised and captured parameters
    input wire jlo_pkg::jlo_link_cfg_t link_cfg,
    output jlo_pkg::jlo_link_cfg_t     rx_cfg
);
    // one capture stage, so checks see what a receiver would latch
    always_ff @(posedge mclk)
        rx_cfg <= rst_b ? link_cfg : '0;
endmodule // jlo_rx_model

// ### tb/test_jlo_override_bank.sv
// self-checking bench for the link override register bank
`timescale 1ns/1ps
`include "jlo_regs.svh"
module test_jlo_override_bank;
    typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] r;} jlo_row_t;
    logic                   mclk = 1'b0;
    logic                   rst_b = 1'b0;
    logic [7:0]             reg_addr = 8'h00;
    logic [15:0]            reg_wdata = 16'h0000;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [15:0]            reg_rdata;
    logic [31:0]            computed_fchk = 32'h44332211;
    jlo_pkg::jlo_link_cfg_t link_cfg;
    jlo_pkg::jlo_link_cfg_t rx_cfg;
    int                     miscompares = 0;
    int                     cmp_count = 0;
    jlo_row_t rows [8] = '{'{`JLO_ADDR_FCHK_12, 16'ha55a, 16'ha55a},
        '{`JLO_ADDR_FCHK_34, 16'h3cc3, 16'h3cc3}, '{`JLO_ADDR_IDENT_12, 16'h1f0b, 16'h1f0b},
        '{`JLO_ADDR_IDENT_34, 16'h0e15, 16'h0e15}, '{`JLO_ADDR_MF_FORCE, 16'hfc00, 16'hfc00},
        '{`JLO_ADDR_VER_SUB, 16'he0e0, 16'he0e0}, '{8'h9a, 16'hffff, 16'h0000},
        '{`JLO_ADDR_LANE_CTRL, 16'hff10, 16'hff10}};
    always #2.5 mclk = ~mclk;
    jlo_override_bank #(.LANES(4)) jlo_override_bank_inst (.mclk(mclk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .computed_fchk(computed_fchk), .link_cfg(link_cfg));
    jlo_rx_model jlo_rx_model_inst (.mclk(mclk), .rst_b(rst_b), .link_cfg(link_cfg),
        .rx_cfg(rx_cfg));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        reg_wr <= w;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(32'(reg_rdata), 32'(e));
        @(posedge mclk);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd_chk(`JLO_ADDR_LANE_CTRL, 16'h0000);
        // each field write is followed at once by a control write
        foreach (rows[i])
        begin
            acc(1'b1, rows[i].a, rows[i].w);
            acc(1'b1, `JLO_ADDR_LANE_CTRL, 16'hff10);
            rd_chk(rows[i].a, rows[i].r);
        end
        repeat (2) @(posedge mclk);
        chk(32'(rx_cfg.lane_ident), 32'({5'h15, 5'h0e, 5'h0b, 5'h1f}));
        chk(rx_cfg.lane_fchk, 32'hc33c5aa5);
        chk(32'(rx_cfg[11:0]), 32'({3'h7, 3'h7, 1'b1, 5'h1f}));
        computed_fchk <= 32'h88776655;
        acc(1'b1, `JLO_ADDR_LANE_CTRL, 16'h0000);
        acc(1'b1, `JLO_ADDR_MF_FORCE, 16'h7c00);
        acc(1'b0, 8'h00, 16'h0000);
        repeat (3) @(posedge mclk);
        chk(32'(rx_cfg.lane_ident), 32'({5'h04, 5'h03, 5'h02, 5'h01}));
        chk(rx_cfg.lane_fchk, 32'h88776655);
        chk(32'(rx_cfg[11:0]), 32'({3'h1, 3'h1, 1'b0, 5'h00}));
        // mid-run reset: outputs clear, registers clear, defaults return after release
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(32'(link_cfg.lane_ident), 32'h0);
        @(posedge mclk);
        rst_b <= 1'b1;
        rd_chk(`JLO_ADDR_MF_FORCE, 16'h0000);
        repeat (2) @(posedge mclk);
        chk(32'(rx_cfg.lane_ident), 32'({5'h04, 5'h03, 5'h02, 5'h01}));
        final_report();
    end
    initial
    begin
        repeat (1000) @(posedge mclk);
        miscompares++;
        final_report();
    end
endmodule // test_jlo_override_bank
